// [design/ext_bus_ctrl.sv]
// external bus controller: windows, chip selects, ready, hold arbitration
`timescale 1ns/1ps
// What this block does
// R1 - single-chip mode, or mux/demux bus with 8/16-bit data, 16-24 bit address
// R2 - demux: address on address port, data on data port or its low byte
// R3 - mux: one port carries address first, then data
// R4 - cycle time, tri-state time, address strobe length, rw delay programmable
// R5 - four address windows, each a select plus bus configuration pair
// R6 - overlapping windows: four beats three, two beats one
// R7 - addresses outside all windows use the default configuration
// R8 - five active-low chip selects: four windows plus default
// R9 - unlatched mode bypasses filtering; selects decoded straight from address
// R10 - ready input lets slow devices stretch an access
// R11 - arbitration pins controlled only once arbitration enable is set
// R12 - master after reset; port6 bit7 direction one makes acknowledge an input
// R13 - segment port drives 8, 4, 2 or 0 upper lines by space size
// R14 - configurer limits segment lines to four when the CAN pins are needed
// R15 - up to 16 Mbytes of external memory addressable
// R16 - byte and word accesses at any address
// R17 - on hold: finish cycle, float bus, acknowledge; request bus back when needed
// R18 - winning window select held for whole access, others inactive
// R19 - not ready inserts waits, address, data and strobes held stable
module ext_bus_ctrl (
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst,
   input  wire logic             i_req,
   input  wire logic [23:0]      i_addr,
   input  wire logic             i_write,
   input  wire logic             i_word,
   input  wire logic [15:0]      i_wdata,
   input  wire logic             i_bus_enable,
   input  wire logic [1:0]       i_segment_size,
   input  wire logic             i_unlatched_select_mode,
   input  wire logic             i_arbitration_enable,
   input  wire logic             i_port6_bit7_direction,
   input  wire logic [3:0][15:0] i_window_address_select,
   input  wire logic [3:0][15:0] i_window_bus_config,
   input  wire logic [15:0]      i_default_bus_config,
   input  wire logic             i_ready_n,
   input  wire logic             i_hold_n,
   input  wire logic             i_hold_ack_n,
   input  wire logic [15:0]      i_data_port,
   output logic                  o_ack,
   output logic      [15:0]      o_rdata,
   output logic                  o_busy,
   output logic                  o_waiting,
   output logic                  o_ale,
   output logic                  o_rd_n,
   output logic                  o_wr_n,
   output logic                  o_bhe_n,
   output logic      [15:0]      o_address_port,
   output logic      [7:0]       o_segment_addr,
   output logic                  o_ctrl_oe_n,
   output logic      [15:0]      o_data_port,
   output logic                  o_data_port_oe_n,
   output logic      [4:0]       o_cs_n,
   output logic                  o_bus_request_out_n,
   output logic                  o_hold_ack_n,
   output logic                  o_hold_ack_oe_n
);
   typedef struct packed {
      ext_bus_pkg::bus_state_t st;
      logic [23:0] addr;
      logic [15:0] wdata;
      logic        write;
      logic        word;
      logic        split;
      logic        second;
      logic        arb_on;
      logic        slave;
      logic [15:0] cfg;
      logic [4:0]  cs_sel;
      logic [4:0]  cnt;
      logic [15:0] rdata;
      logic        ack;
      logic        busy;
      logic        waiting;
      logic        ale;
      logic        rd_n;
      logic        wr_n;
      logic        bhe_n;
      logic [15:0] addr_port;
      logic [7:0]  seg;
      logic [15:0] data_out;
      logic        data_oe_n;
      logic        ctrl_oe_n;
      logic [4:0]  cs_n;
      logic        bus_request_out_n;
      logic        hold_acknowledge_n;
      logic        hold_acknowledge_oe_n;
   } ctl_t;

   ctl_t        r;
   ctl_t        n;
   logic [18:0] sync_q;
   logic        ready_n_s;
   logic        hold_n_s;
   logic        hold_acknowledge_n_s;
   logic [15:0] data_s;
   logic [15:0] dec_cfg;
   logic [4:0]  dec_cs_n;
   logic [23:0] cur_a;
   logic        hold_req;
   logic        grant;
   logic        can_start;
   logic        byte_cyc;
   logic [7:0]  lane_in;
   logic [7:0]  lane_out;

   pin_sync #(
      .W       (19),
      .RST_VAL (ext_bus_pkg::SYNC_RST)
   ) u_sync (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_d       ({i_ready_n, i_hold_n, i_hold_ack_n, i_data_port}),
      .o_q       (sync_q)
   );

   assign {ready_n_s, hold_n_s, hold_acknowledge_n_s, data_s} = sync_q;

   window_decode u_dec (
      .i_addr                  (i_addr),
      .i_window_address_select (i_window_address_select),
      .i_window_bus_config     (i_window_bus_config),
      .i_default_bus_config    (i_default_bus_config),
      .o_cfg                   (dec_cfg),
      .o_cs_n                  (dec_cs_n)
   );

   function automatic logic [4:0] ale_cnt(input logic [15:0] cfg);
      return (cfg[ext_bus_pkg::CFG_ALE_BIT] ? ext_bus_pkg::ALE_LONG_CYC
                                            : ext_bus_pkg::ALE_SHORT_CYC) - 5'h01;
   endfunction

   function automatic logic [7:0] seg_mask(input logic [1:0] size);
      unique case (size)
         ext_bus_pkg::SEG_64K:  return ext_bus_pkg::SEG_MASK_64K;
         ext_bus_pkg::SEG_256K: return ext_bus_pkg::SEG_MASK_256K;
         ext_bus_pkg::SEG_1M:   return ext_bus_pkg::SEG_MASK_1M;
         ext_bus_pkg::SEG_16M:  return ext_bus_pkg::SEG_MASK_16M;
      endcase
   endfunction

   always_comb
   begin
      n        = r;
      n.ack    = 1'b0;
      n.arb_on = r.arb_on | i_arbitration_enable;   // R11
      n.slave  = i_port6_bit7_direction;   // R12
      cur_a    = r.addr + {23'h000000, r.second};   // R15
      hold_req = r.arb_on && !hold_n_s;
      // in slave mode the bus is ours only while our request is acknowledged
      grant     = !(r.arb_on && r.slave) || (!r.bus_request_out_n && !hold_acknowledge_n_s);
      can_start = (r.st == ext_bus_pkg::ST_IDLE) && i_req && !hold_req && grant;
      byte_cyc  = !r.word || r.split;
      lane_in   = (r.cfg[ext_bus_pkg::CFG_BYTE_BIT] || !cur_a[0]) ? data_s[7:0]
                                                                 : data_s[15:8];   // R2
      lane_out  = r.second ? r.wdata[15:8] : r.wdata[7:0];
      n.seg       = cur_a[23:16] & seg_mask(i_segment_size);   // R13
      n.addr_port = cur_a[15:0];   // R2
      n.hold_acknowledge_oe_n = !(n.arb_on && !n.slave);   // R12
      if (r.cfg[ext_bus_pkg::CFG_BYTE_BIT])
         n.bhe_n = 1'b1;
      else
         n.bhe_n = byte_cyc && !cur_a[0];   // R16
      unique case (r.st)
         ext_bus_pkg::ST_IDLE:
         begin
            if (r.arb_on && r.slave)
               n.bus_request_out_n = !(i_req && !hold_req);   // R17
            n.ctrl_oe_n = !grant;
            if (hold_req && !r.slave)
            begin
               n.st        = ext_bus_pkg::ST_HELD;   // R17
               n.ctrl_oe_n = 1'b1;
               n.data_oe_n = 1'b1;
               n.hold_acknowledge_n    = 1'b0;
               n.cs_n      = ext_bus_pkg::CS_NONE_N;
            end
            else if (can_start)
            begin
               n.addr   = i_addr;
               n.wdata  = i_wdata;
               n.write  = i_write;
               n.word   = i_word;
               n.second = 1'b0;
               n.cfg    = dec_cfg;   // R7
               n.cs_sel = dec_cs_n;
               // one word access on the 8-bit bus or at an odd address takes two byte cycles
               n.split  = i_word && (dec_cfg[ext_bus_pkg::CFG_BYTE_BIT] || i_addr[0]);   // R16
               n.cnt    = ale_cnt(dec_cfg);
               if (i_unlatched_select_mode)
                  n.cs_n = dec_cs_n;   // R9
               if (!i_bus_enable)
               begin
                  n.ack   = 1'b1;   // R1
                  n.rdata = 16'h0000;
                  n.cnt   = 5'h00;
                  n.st    = ext_bus_pkg::ST_RECOVER;
               end
               else
                  n.st = ext_bus_pkg::ST_ADDR;
            end
         end
         ext_bus_pkg::ST_ADDR:
         begin
            n.ale    = 1'b1;
            n.cs_n   = r.cs_sel;   // R18
            n.rd_n   = 1'b1;
            n.wr_n   = 1'b1;
            if (r.cfg[ext_bus_pkg::CFG_MUX_BIT])
            begin
               n.data_out  = cur_a[15:0];   // R3
               n.data_oe_n = 1'b0;
            end
            else
               n.data_oe_n = 1'b1;
            if (r.cnt != 5'h00)
               n.cnt = r.cnt - 5'h01;   // R4
            else if (r.cfg[ext_bus_pkg::CFG_RWDLY_BIT])
               n.st = ext_bus_pkg::ST_DELAY;   // R4
            else
            begin
               n.st  = ext_bus_pkg::ST_STROBE;
               n.cnt = 5'(r.cfg[ext_bus_pkg::CFG_WAIT_LSB +: ext_bus_pkg::CFG_WAIT_W])
                       + ext_bus_pkg::STROBE_LAG_CYC;   // R4
            end
         end
         ext_bus_pkg::ST_DELAY:
         begin
            n.ale       = 1'b0;
            n.data_out  = byte_cyc ? {lane_out, lane_out} : r.wdata;
            n.data_oe_n = !r.write;
            n.st        = ext_bus_pkg::ST_STROBE;
            n.cnt       = 5'(r.cfg[ext_bus_pkg::CFG_WAIT_LSB +: ext_bus_pkg::CFG_WAIT_W])
                          + ext_bus_pkg::STROBE_LAG_CYC;
         end
         ext_bus_pkg::ST_STROBE:
         begin
            n.ale       = 1'b0;
            n.rd_n      = r.write;
            n.wr_n      = !r.write;
            n.data_out  = byte_cyc ? {lane_out, lane_out} : r.wdata;   // R2
            n.data_oe_n = !r.write;
            n.waiting   = 1'b0;
            if (r.cnt != 5'h00)
               n.cnt = r.cnt - 5'h01;
            else if (r.cfg[ext_bus_pkg::CFG_RDY_BIT] && ready_n_s)
               n.waiting = 1'b1;   // R10 R19
            else
            begin
               n.rd_n = 1'b1;
               n.wr_n = 1'b1;
               if (!byte_cyc)
                  n.rdata = data_s;
               else if (r.second)
                  n.rdata[15:8] = lane_in;
               else
                  n.rdata = {8'h00, lane_in};
               if (r.split && !r.second)
               begin
                  n.second = 1'b1;
                  n.st     = ext_bus_pkg::ST_ADDR;
                  n.cnt    = ale_cnt(r.cfg);
               end
               else
               begin
                  n.ack = 1'b1;
                  n.st  = ext_bus_pkg::ST_RECOVER;
                  n.cnt = (!r.write && r.cfg[ext_bus_pkg::CFG_TRI_BIT]) ? ext_bus_pkg::TRI_CYC
                                                                        : 5'h00;   // R4
                  if (!i_unlatched_select_mode)
                     n.cs_n = ext_bus_pkg::CS_NONE_N;   // R18
               end
            end
         end
         ext_bus_pkg::ST_RECOVER:
         begin
            // read turnaround: data lines stay released before anyone drives them
            n.data_oe_n = 1'b1;
            if (r.cnt != 5'h00)
               n.cnt = r.cnt - 5'h01;
            else
               n.st = ext_bus_pkg::ST_IDLE;
         end
         ext_bus_pkg::ST_HELD:
         begin
            n.bus_request_out_n = !i_req;   // R17
            if (!hold_req)
            begin
               n.hold_acknowledge_n    = 1'b1;
               n.bus_request_out_n    = 1'b1;
               n.ctrl_oe_n = 1'b0;
               n.st        = ext_bus_pkg::ST_IDLE;
            end
         end
         default:
            n.st = ext_bus_pkg::ST_IDLE;
      endcase
      if (!n.arb_on)
      begin
         n.bus_request_out_n = 1'b1;   // R11
         n.hold_acknowledge_n = 1'b1;
      end
      n.busy = (n.st != ext_bus_pkg::ST_IDLE);
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         r <= '{st: ext_bus_pkg::ST_IDLE, rd_n: 1'b1, wr_n: 1'b1, bhe_n: 1'b1,
                data_oe_n: 1'b1, cs_n: ext_bus_pkg::CS_NONE_N,
                cs_sel: ext_bus_pkg::CS_NONE_N, bus_request_out_n: 1'b1, hold_acknowledge_n: 1'b1,
                hold_acknowledge_oe_n: 1'b1, default: '0};
      else
         r <= n;
   end

   assign o_ack               = r.ack;
   assign o_rdata             = r.rdata;
   assign o_busy              = r.busy;
   assign o_waiting           = r.waiting;
   assign o_ale               = r.ale;
   assign o_rd_n              = r.rd_n;
   assign o_wr_n              = r.wr_n;
   assign o_bhe_n             = r.bhe_n;
   assign o_address_port      = r.addr_port;
   assign o_segment_addr      = r.seg;
   assign o_ctrl_oe_n         = r.ctrl_oe_n;
   assign o_data_port         = r.data_out;
   assign o_data_port_oe_n    = r.data_oe_n;
   assign o_cs_n              = r.cs_n;
   assign o_bus_request_out_n = r.bus_request_out_n;
   assign o_hold_ack_n        = r.hold_acknowledge_n;
   assign o_hold_ack_oe_n     = r.hold_acknowledge_oe_n;

   single_chip_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R1
      (can_start && !i_bus_enable) |=> o_ack && o_rd_n && o_wr_n)
      else $error("single-chip access not answered at once");

   strobe_excl_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R2
      !(!o_rd_n && !o_wr_n))
      else $error("read and write strobes both active");

   mux_addr_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R3
      (o_ale && r.cfg[ext_bus_pkg::CFG_MUX_BIT]) |->
         (o_data_port == o_address_port) && !o_data_port_oe_n)
      else $error("multiplexed address phase lacks address on data port");

   ale_long_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R4
      ($rose(o_ale) && r.cfg[ext_bus_pkg::CFG_ALE_BIT]) |=> o_ale ##1 !o_ale)
      else $error("long address strobe not two cycles");

   slave_in_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R12
      r.slave |-> o_hold_ack_oe_n)
      else $error("acknowledge driven in slave mode");

   arb_off_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R11
      !r.arb_on |-> o_bus_request_out_n && o_hold_ack_n && (r.st != ext_bus_pkg::ST_HELD))
      else $error("arbitration active before enable");

   seg_mask_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R13
      ($past(i_segment_size) == ext_bus_pkg::SEG_256K) |-> (o_segment_addr[7:2] == 6'h00))
      else $error("segment lines beyond space size driven");

   hold_float_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R17
      (!o_hold_ack_n && !o_hold_ack_oe_n) |-> o_ctrl_oe_n && o_data_port_oe_n && (o_cs_n == 5'h1f))
      else $error("bus driven while hold acknowledged");

   cs_single_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R18
      (r.st == ext_bus_pkg::ST_STROBE) |-> ($countones(~o_cs_n) == 1))
      else $error("chip select not exactly one during access");

   wait_stable_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R19
      o_waiting |->
         $stable(o_address_port) && $stable(o_data_port) && $stable(o_rd_n) && $stable(o_wr_n))
      else $error("bus outputs moved during wait");

endmodule

// [design/ext_bus_pkg.sv]
// constants, field layouts and states shared by the external bus controller
package ext_bus_pkg;

   localparam int ADDR_W  = 24;
   localparam int DATA_W  = 16;
   localparam int NUM_WIN = 4;
   localparam int NUM_CS  = 5;

   // window_bus_config / default_bus_config field positions
   localparam int CFG_WAIT_LSB  = 0;
   localparam int CFG_WAIT_W    = 4;
   localparam int CFG_TRI_BIT   = 4;
   localparam int CFG_RWDLY_BIT = 5;
   localparam int CFG_BYTE_BIT  = 6;
   localparam int CFG_MUX_BIT   = 7;
   localparam int CFG_ALE_BIT   = 9;
   localparam int CFG_EN_BIT    = 10;
   localparam int CFG_RDY_BIT   = 12;

   // window_address_select field positions: base in 4 KB units, size code
   localparam int SEL_SIZE_LSB = 0;
   localparam int SEL_SIZE_W   = 4;
   localparam int SEL_BASE_LSB = 4;
   localparam int SEL_BASE_W   = 12;

   // segment space codes and the upper address lines each one enables
   localparam logic [1:0] SEG_64K    = 2'h0;
   localparam logic [1:0] SEG_256K   = 2'h1;
   localparam logic [1:0] SEG_1M     = 2'h2;
   localparam logic [1:0] SEG_16M    = 2'h3;
   localparam logic [7:0] SEG_MASK_64K  = 8'h00;
   localparam logic [7:0] SEG_MASK_256K = 8'h03;
   localparam logic [7:0] SEG_MASK_1M   = 8'h0f;
   localparam logic [7:0] SEG_MASK_16M  = 8'hff;

   // cycle counts
   localparam logic [4:0] ALE_SHORT_CYC  = 5'h01;
   localparam logic [4:0] ALE_LONG_CYC   = 5'h02;
   // two cycles of pin synchroniser lag plus one for the pins to settle under the strobe
   localparam logic [4:0] STROBE_LAG_CYC = 5'h03;
   localparam logic [4:0] TRI_CYC        = 5'h01;

   // reset values
   localparam logic [4:0]  CS_NONE_N = 5'h1f;
   localparam logic [18:0] SYNC_RST  = 19'h70000;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_DELAY,
      ST_STROBE,
      ST_RECOVER,
      ST_HELD
   } bus_state_t;

endpackage

// [design/pin_sync.sv]
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         meta_r <= RST_VAL;
         o_q    <= RST_VAL;
      end
      else
      begin
         meta_r <= i_d;
         o_q    <= meta_r;
      end
   end
endmodule

// [design/window_decode.sv]
// address window match, priority pick and chip select decode
`timescale 1ns/1ps
module window_decode (
   input  wire logic [23:0]      i_addr,
   input  wire logic [3:0][15:0] i_window_address_select,
   input  wire logic [3:0][15:0] i_window_bus_config,
   input  wire logic [15:0]      i_default_bus_config,
   output logic      [15:0]      o_cfg,
   output logic      [4:0]       o_cs_n
);
   logic [3:0] hit;
   logic [2:0] win;

   function automatic logic win_match(input logic [23:0] a, input logic [15:0] sel);
      logic [11:0] m;
      m = 12'hfff << sel[ext_bus_pkg::SEL_SIZE_LSB +: ext_bus_pkg::SEL_SIZE_W];
      return ((a[23:12] ^ sel[ext_bus_pkg::SEL_BASE_LSB +: ext_bus_pkg::SEL_BASE_W]) & m)
             == 12'h000;
   endfunction

   for (genvar g = 0; g < ext_bus_pkg::NUM_WIN; g++)
   begin : g_hit
      assign hit[g] = win_match(i_addr, i_window_address_select[g]) &&
                      i_window_bus_config[g][ext_bus_pkg::CFG_EN_BIT];   // R5
   end

   always_comb
   begin
      win = 3'h0;
      // higher window index wins, so 4 beats 3 and 2 beats 1
      for (int i = 0; i < ext_bus_pkg::NUM_WIN; i++)
      begin
         if (hit[i])
            win = 3'(i + 1);   // R6
      end
      if (win == 3'h0)
         o_cfg = i_default_bus_config;   // R7
      else
         o_cfg = i_window_bus_config[2'(win - 3'h1)];
      o_cs_n = ~(5'h01 << win);   // R8
   end
endmodule

// [sim/ext_mem_model.sv]
// external memory on the demultiplexed 16-bit port with a stretchable ready
`timescale 1ns/1ps
module ext_mem_model (
   input  wire logic        i_ref_clk,
   input  wire logic [15:0] i_addr,
   input  wire logic        i_rd_n,
   input  wire logic        i_wr_n,
   input  wire logic        i_bhe_n,
   input  wire logic [4:0]  i_cs_n,
   input  wire logic [15:0] i_wdata,
   input  wire logic [3:0]  i_slow,
   output logic      [15:0] o_data,
   output logic             o_ready_n
);
   logic [7:0]  mem [256];
   logic [15:0] prev_r = 16'h0000;
   logic [3:0]  cnt_r;
   logic [7:0]  lo;
   logic        sel;
   assign sel = ~&i_cs_n;
   assign lo = {i_addr[7:1], 1'b0};
   // a released bus toggles, so stale data can never pass for a read
   assign o_data = (sel && !i_rd_n) ? {mem[lo + 8'h01], mem[lo]} : ~prev_r;
   // not ready for the first i_slow strobe cycles
   assign o_ready_n = (cnt_r >= i_slow) ? 1'b0 : 1'b1;
   // cleared so that reads of unwritten words keep the released bus toggling
   initial
   begin
      foreach (mem[i])
         mem[i] = 8'h00;
   end
   always @(posedge i_ref_clk)
   begin
      prev_r <= o_data;
      cnt_r <= (i_rd_n && i_wr_n) ? 4'h0 : cnt_r + {3'h0, cnt_r != 4'hf};
      if (sel && !i_wr_n && !i_addr[0])
         mem[lo] <= i_wdata[7:0];
      if (sel && !i_wr_n && !i_bhe_n)
         mem[lo + 8'h01] <= i_wdata[15:8];
   end
endmodule

// [sim/ext_bus_ctrl_tb.sv]
// self-checking bench for the external bus controller
`timescale 1ns/1ps
module ext_bus_ctrl_tb;
   logic             i_ref_clk = 1'b0;
   logic             i_rst = 1'b1;
   logic             i_req = 1'b0;
   logic [23:0]      i_addr = 24'h0;
   logic             i_write = 1'b0;
   logic             i_word = 1'b0;
   logic [15:0]      i_wdata = 16'h0;
   logic             i_bus_enable = 1'b0;
   logic [1:0]       i_segment_size = 2'h3;
   logic             i_unlatched_select_mode = 1'b0;
   logic             i_arbitration_enable = 1'b0;
   logic             i_port6_bit7_direction = 1'b0;
   logic [3:0][15:0] i_window_address_select = '0;
   logic [3:0][15:0] i_window_bus_config = '0;
   logic [15:0]      i_default_bus_config = 16'h0;
   logic             i_hold_n = 1'b1;
   logic             i_hold_ack_n = 1'b1;
   logic [3:0]       slow = 4'h0;
   logic             i_ready_n;
   logic [15:0]      i_data_port;
   logic             o_ack, o_busy, o_waiting, o_ale, o_rd_n, o_wr_n, o_bhe_n;
   logic [15:0]      o_rdata, o_address_port, o_data_port;
   logic [7:0]       o_segment_addr;
   logic [4:0]       o_cs_n;
   logic             o_ctrl_oe_n, o_data_port_oe_n;
   logic             o_bus_request_out_n, o_hold_ack_n, o_hold_ack_oe_n;
   int               n_mismatch = 0;
   int               samples_checked = 0;
   int               cyc = 0;
   int               strb;
   logic [4:0]       cs_seen;
   logic [7:0]       seg_seen;
   logic             wait_seen;
   const logic [7:0] seg_mask [4] = '{8'h00, 8'h03, 8'h0f, 8'hff};

   ext_bus_ctrl u_ext_bus_ctrl (
      .i_ref_clk, .i_rst, .i_req, .i_addr, .i_write, .i_word, .i_wdata, .i_bus_enable,
      .i_segment_size, .i_unlatched_select_mode, .i_arbitration_enable,
      .i_port6_bit7_direction, .i_window_address_select, .i_window_bus_config,
      .i_default_bus_config, .i_ready_n, .i_hold_n, .i_hold_ack_n, .i_data_port,
      .o_ack, .o_rdata, .o_busy, .o_waiting, .o_ale, .o_rd_n, .o_wr_n, .o_bhe_n,
      .o_address_port, .o_segment_addr, .o_ctrl_oe_n, .o_data_port, .o_data_port_oe_n,
      .o_cs_n, .o_bus_request_out_n, .o_hold_ack_n, .o_hold_ack_oe_n
   );

   ext_mem_model u_ext_mem_model (
      .i_ref_clk(i_ref_clk), .i_addr(o_address_port), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n),
      .i_bhe_n(o_bhe_n), .i_cs_n(o_cs_n), .i_wdata(o_data_port), .i_slow(slow),
      .o_data(i_data_port), .o_ready_n(i_ready_n)
   );

   initial
   begin
      forever #12.5 i_ref_clk = ~i_ref_clk;
   end

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // operands held until the ack cycle, then the request drops
   task automatic access(input logic [23:0] a, input logic wr, input logic wd,
                         input logic [15:0] d);
      int k;
      @(negedge i_ref_clk);
      i_req = 1'b1;
      i_addr = a;
      i_write = wr;
      i_word = wd;
      i_wdata = d;
      cs_seen = 5'h1f;
      wait_seen = 1'b0;
      strb = 0;
      for (k = 0; k < 200 && o_ack !== 1'b1; k++)
      begin
         @(negedge i_ref_clk);
         if (o_rd_n === 1'b0 || o_wr_n === 1'b0)
         begin
            cs_seen = o_cs_n;
            seg_seen = o_segment_addr;
            strb++;
         end
         if (o_waiting === 1'b1)
            wait_seen = 1'b1;
      end
      check("ack", o_ack, 1'b1);
      i_req = 1'b0;
      repeat (3) @(negedge i_ref_clk);
   endtask

   always @(posedge i_ref_clk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end

   initial
   begin
      repeat (5) @(negedge i_ref_clk);
      i_rst = 1'b0;
      check("reset pins", {o_ale, o_cs_n, o_ctrl_oe_n, o_data_port_oe_n, o_hold_ack_oe_n},
            9'h0fb);
      access(24'h000010, 1'b0, 1'b1, 16'h0);
      check("single chip cs", {strb[3:0], cs_seen}, 9'h01f);
      i_bus_enable = 1'b1;
      access(24'h000010, 1'b1, 1'b1, 16'hbeef);
      access(24'h000010, 1'b0, 1'b1, 16'h0);
      check("word read", o_rdata, 16'hbeef);
      check("default cs", cs_seen, 5'h1e);
      access(24'h000021, 1'b1, 1'b1, 16'h1234);
      access(24'h000021, 1'b0, 1'b0, 16'h0);
      check("odd low byte", o_rdata[7:0], 8'h34);
      access(24'h000022, 1'b0, 1'b0, 16'h0);
      check("odd high byte", o_rdata[7:0], 8'h12);
      foreach (seg_mask[s])
      begin
         i_segment_size = 2'(s);
         access(24'ha50100, 1'b0, 1'b1, 16'h0);
         check("segment", seg_seen, 8'ha5 & seg_mask[s]);
      end
      i_segment_size = 2'h2;
      i_default_bus_config = 16'h0005;
      access(24'h000010, 1'b0, 1'b1, 16'h0);
      check("strobe len", strb[7:0], 8'h05 + 8'(ext_bus_pkg::STROBE_LAG_CYC));
      // multiplexed, long address strobe, rw delay, tri-state after read
      i_default_bus_config = 16'h02b0;
      access(24'h000030, 1'b1, 1'b1, 16'hc3a5);
      access(24'h000030, 1'b0, 1'b1, 16'h0);
      check("mux read", o_rdata, 16'hc3a5);
      i_default_bus_config = 16'h1000;
      slow = 4'h4;
      access(24'h000040, 1'b1, 1'b1, 16'h5a5a);
      access(24'h000040, 1'b0, 1'b1, 16'h0);
      check("ready data", {wait_seen, o_rdata}, 17'h15a5a);
      i_window_address_select = {16'h0200, 16'h0200, 16'h0100, 16'h0100};
      i_window_bus_config = {4{16'h0400}};
      access(24'h010004, 1'b0, 1'b1, 16'h0);
      check("win2 over win1", cs_seen, 5'h1b);
      access(24'h020004, 1'b0, 1'b1, 16'h0);
      check("win4 over win3", cs_seen, 5'h0f);
      i_window_bus_config[1] = 16'h0000;
      access(24'h010004, 1'b0, 1'b1, 16'h0);
      check("win1 alone", cs_seen, 5'h1d);
      i_unlatched_select_mode = 1'b1;
      access(24'h010004, 1'b0, 1'b1, 16'h0);
      check("unlatched cs", o_cs_n, 5'h1d);
      i_hold_n = 1'b0;
      repeat (6) @(negedge i_ref_clk);
      check("hold ignored", {o_hold_ack_oe_n, o_hold_ack_n}, 2'h3);
      i_arbitration_enable = 1'b1;
      repeat (6) @(negedge i_ref_clk);
      fork
         access(24'h000010, 1'b0, 1'b1, 16'h0);
         begin
            repeat (6) @(negedge i_ref_clk);
            check("held pins", {o_bus_request_out_n, o_hold_ack_oe_n, o_hold_ack_n}, 3'h0);
            check("float", {o_ack, o_ctrl_oe_n, o_data_port_oe_n, o_cs_n}, 8'h7f);
            i_hold_n = 1'b1;
         end
      join
      check("after hold", {o_hold_ack_n, o_rdata}, 17'h1beef);
      i_port6_bit7_direction = 1'b1;
      fork
         access(24'h000010, 1'b0, 1'b1, 16'h0);
         begin
            repeat (6) @(negedge i_ref_clk);
            check("slave req", {o_bus_request_out_n, o_hold_ack_oe_n}, 2'h1);
            check("slave idle", {o_ctrl_oe_n, o_busy}, 2'h2);
            i_hold_ack_n = 1'b0;
         end
      join
      check("slave read", o_rdata, 16'hbeef);
      give_verdict();
   end
endmodule
